// [pbr_pkg.sv]
// Package with register map, reset values, limits and timing constants
package pbr_pkg;
    // Register offsets (word addresses on the parameter map)
    localparam logic [15:0] PBR_OFS_CONTRAST = 16'h0023;
    localparam logic [15:0] PBR_OFS_OP_BRIGHT = 16'h0024;
    localparam logic [15:0] PBR_OFS_PROFILE = 16'h0025;
    localparam logic [15:0] PBR_OFS_PASSWORD = 16'h0032;
    localparam logic [15:0] PBR_OFS_ENERGY_CLR = 16'h01FB;
    localparam logic [15:0] PBR_OFS_STBY_TIMEOUT = 16'h02EA;
    localparam logic [15:0] PBR_OFS_STBY_BRIGHT = 16'h02EB;
    localparam logic [15:0] PBR_OFS_FW_RELEASE = 16'h02EE;
    localparam logic [15:0] PBR_OFS_SERIAL_LO = 16'h02F2;
    localparam logic [15:0] PBR_OFS_SERIAL_HI = 16'h02F3;

    // Reset values
    localparam logic [3:0] PBR_RST_CONTRAST = 4'h5;
    localparam logic [3:0] PBR_RST_OP_BRIGHT = 4'h6;
    localparam logic [3:0] PBR_RST_STBY_BRIGHT = 4'h0;
    localparam logic [1:0] PBR_RST_PROFILE = 2'h0;
    localparam logic [15:0] PBR_RST_PASSWORD = 16'h0000;
    localparam logic [15:0] PBR_RST_STBY_TIMEOUT = 16'h0384;

    // Value limits
    localparam logic [15:0] PBR_LEVEL_MAX = 16'h0009;
    localparam logic [15:0] PBR_PROFILE_MAX = 16'h0003;
    localparam logic [1:0] PBR_PROFILE_CUSTOM = 2'h3;
    localparam logic [15:0] PBR_PASSWORD_MAX = 16'h03E7;
    localparam logic [15:0] PBR_TIMEOUT_MIN = 16'h003C;
    localparam logic [15:0] PBR_TIMEOUT_MAX = 16'h270F;
    localparam logic [15:0] PBR_ENERGY_CLR_CODE = 16'h0001;
    localparam logic [31:0] PBR_SEC_DISPLAY_MAX = 32'h000F_423F;
    localparam logic [19:0] PBR_HOURS_DISPLAY_MAX = 20'hF_423F;

    // Timing: system clock and derived one-second tick
    localparam int PBR_CLK_HZ = 200_000_000;
    localparam int PBR_TICK_S = 1;
    localparam int PBR_TICK_CYCLES = PBR_CLK_HZ * PBR_TICK_S;
    // Seconds in a tenth of an hour
    localparam logic [8:0] PBR_TENTH_HOUR_S = 9'h168;

    typedef enum logic [1:0] {
        PBR_MENU_IDLE = 2'b00,
        PBR_MENU_PASSWORD = 2'b01,
        PBR_MENU_CT = 2'b10
    } pbr_menu_t;
endpackage

// [pbr_panel_ctrl.sv]
// Front-panel control: profile, password gate, backlight, contrast, run-time counters
//
// Function
// - Profile select accepts 0..3, 3 is custom
// - Custom profile only loadable over remote path
// - No password set: go straight to CT menu
// - Password screen starts with digits 000
// - Blink digit, button2 changes, button1 advances
// - CT menu opens only on password match
// - Writing 1 clears all energy meters together
// - Rotation shown only with three distinct phases
// - Contrast 0..9 in unit steps, default 5
// - Operation brightness after button press or restart
// - Inactivity timeout selects standby, buttons restore
// - Timeout 60..9999 seconds, default 900
// - Brightness levels 0 minimum to 9 maximum
// - Standby brightness defaults to level 0
// - Operating hours in 0.1 h, never reset
// - Comparator time grows only during violation
// - Seconds shown up to 999999, then hours
// - Display index 1..6 comparators, none hours
// - Comparator reset clears all six, remote only
// - Displayed hours limited to 99999.9 h
// - Six-digit serial number, read only
// - Three-digit firmware release, read only
`timescale 1ns/100ps
module pbr_panel_ctrl
    import pbr_pkg::*;
#(
    parameter int TICK_CYCLES = PBR_TICK_CYCLES,
    // Arbitrary identity values
    parameter logic [19:0] SERIAL_NUMBER = 20'h1E240,
    parameter logic [9:0] FW_RELEASE = 10'h064,
    parameter int NUM_CMP = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic btn1_pin,
    input wire logic btn2_pin,
    input wire logic btn3_pin,
    input wire logic prog_pin,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic remote_profile_load,
    input wire logic remote_cmp_time_clr,
    input wire logic [2:0] phase_present,
    input wire logic phase_duplicate,
    input wire logic rotation_cw,
    input wire logic measuring,
    input wire logic [NUM_CMP-1:0] cmp_violation,
    input wire logic [2:0] disp_sel,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    output logic [1:0] profile_sel,
    output logic profile_reload,
    output logic [3:0] lcd_contrast,
    output logic [3:0] backlight_level,
    output logic standby_active,
    output logic energy_clear,
    output logic rotation_show,
    output logic rotation_dir_cw,
    output logic [1:0] menu_state,
    output logic [11:0] pw_digits,
    output logic [1:0] pw_digit_sel,
    output logic pw_blink_on,
    output logic [19:0] disp_value,
    output logic [2:0] disp_index,
    output logic disp_in_hours
);
    initial begin
        if (TICK_CYCLES < 2 || NUM_CMP != 6 || FW_RELEASE > 10'd999) begin
            $error("bad parameter");
        end
        if (SERIAL_NUMBER < 20'd100000 || SERIAL_NUMBER > 20'd999999) begin
            $error("serial needs six digits");
        end
    end

    // Pin synchronisers and press edges
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    wire [3:0] pin_raw = {prog_pin, btn3_pin, btn2_pin, btn1_pin};
    wire [3:0] press = pin_sync_q & ~pin_prev_q;
    wire btn1_press = press[0];
    wire btn2_press = press[1];
    wire any_btn_press = |press[2:0];
    wire prog_press = press[3];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Common one-second tick
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    logic [TW-1:0] tick_cnt_q;
    wire tick = (tick_cnt_q == TICK_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Register decode
    wire sel_contrast = (reg_addr == PBR_OFS_CONTRAST);
    wire sel_op_bright = (reg_addr == PBR_OFS_OP_BRIGHT);
    wire sel_profile = (reg_addr == PBR_OFS_PROFILE);
    wire sel_password = (reg_addr == PBR_OFS_PASSWORD);
    wire sel_energy_clr = (reg_addr == PBR_OFS_ENERGY_CLR);
    wire sel_timeout = (reg_addr == PBR_OFS_STBY_TIMEOUT);
    wire sel_stby_bright = (reg_addr == PBR_OFS_STBY_BRIGHT);
    wire sel_fw = (reg_addr == PBR_OFS_FW_RELEASE);
    wire sel_serial_lo = (reg_addr == PBR_OFS_SERIAL_LO);
    wire sel_serial_hi = (reg_addr == PBR_OFS_SERIAL_HI);
    wire sel_any = sel_contrast | sel_op_bright | sel_profile | sel_password |
                   sel_energy_clr | sel_timeout | sel_stby_bright | sel_fw |
                   sel_serial_lo | sel_serial_hi;
    wire sel_ro = sel_fw | sel_serial_lo | sel_serial_hi;

    wire level_ok = (reg_wdata <= PBR_LEVEL_MAX);
    wire profile_ok = (reg_wdata <= PBR_PROFILE_MAX);
    // Custom profile contents can only arrive over the remote path
    wire profile_load_ok = (reg_wdata[1:0] != PBR_PROFILE_CUSTOM) | remote_profile_load;
    wire password_ok = (reg_wdata <= PBR_PASSWORD_MAX);
    wire timeout_ok = (reg_wdata >= PBR_TIMEOUT_MIN) && (reg_wdata <= PBR_TIMEOUT_MAX);
    wire value_ok = ((sel_contrast | sel_op_bright | sel_stby_bright) & level_ok) |
                    (sel_profile & profile_ok & profile_load_ok) |
                    (sel_password & password_ok) |
                    (sel_timeout & timeout_ok) |
                    sel_energy_clr;
    wire wr_ok = reg_wr & value_ok;
    wire wr_bad = reg_wr & (~sel_any | sel_ro | ~value_ok);
    wire rd_bad = reg_rd & ~sel_any;

    logic [3:0] contrast_q;
    logic [3:0] op_bright_q;
    logic [3:0] stby_bright_q;
    logic [1:0] profile_q;
    logic profile_reload_q;
    logic [15:0] password_q;
    logic [15:0] timeout_q;
    logic energy_clear_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            contrast_q <= PBR_RST_CONTRAST;
            op_bright_q <= PBR_RST_OP_BRIGHT;
            stby_bright_q <= PBR_RST_STBY_BRIGHT;
            profile_q <= PBR_RST_PROFILE;
            profile_reload_q <= 1'b0;
            password_q <= PBR_RST_PASSWORD;
            timeout_q <= PBR_RST_STBY_TIMEOUT;
            energy_clear_q <= 1'b0;
        end else begin
            if (wr_ok && sel_contrast) begin
                contrast_q <= reg_wdata[3:0];
            end
            if (wr_ok && sel_op_bright) begin
                op_bright_q <= reg_wdata[3:0];
            end
            if (wr_ok && sel_stby_bright) begin
                stby_bright_q <= reg_wdata[3:0];
            end
            if (wr_ok && sel_profile) begin
                profile_q <= reg_wdata[1:0];
            end
            profile_reload_q <= wr_ok & sel_profile;
            if (wr_ok && sel_password) begin
                password_q <= reg_wdata;
            end
            if (wr_ok && sel_timeout) begin
                timeout_q <= reg_wdata;
            end
            // One pulse clears all three energy meters at once
            energy_clear_q <= wr_ok & sel_energy_clr & (reg_wdata == PBR_ENERGY_CLR_CODE);
        end
    end

    // Read data mux
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (sel_contrast) rd_mux = {12'h000, contrast_q};
        if (sel_op_bright) rd_mux = {12'h000, op_bright_q};
        if (sel_stby_bright) rd_mux = {12'h000, stby_bright_q};
        if (sel_profile) rd_mux = {14'h0000, profile_q};
        if (sel_password) rd_mux = password_q;
        if (sel_timeout) rd_mux = timeout_q;
        if (sel_fw) rd_mux = {6'h00, FW_RELEASE};
        if (sel_serial_lo) rd_mux = SERIAL_NUMBER[15:0];
        if (sel_serial_hi) rd_mux = {12'h000, SERIAL_NUMBER[19:16]};
    end

    logic [15:0] rdata_q;
    logic rvalid_q;
    logic err_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            err_q <= wr_bad | rd_bad;
            if (reg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Password gate and programming menu
    pbr_menu_t menu_q;
    logic [3:0] digit_q [3];
    logic [1:0] digit_sel_q;
    logic blink_q;
    wire [15:0] entered = 16'(digit_q[0]) * 16'd100 + 16'(digit_q[1]) * 16'd10 +
                          16'(digit_q[2]);
    wire pw_match = (entered == password_q);
    wire last_digit = (digit_sel_q == 2'd2);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            menu_q <= PBR_MENU_IDLE;
            digit_sel_q <= 2'd0;
            blink_q <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                digit_q[i] <= 4'h0;
            end
        end else begin
            blink_q <= tick ? ~blink_q : blink_q;
            unique case (menu_q)
                PBR_MENU_IDLE: begin
                    if (prog_press) begin
                        digit_sel_q <= 2'd0;
                        for (int i = 0; i < 3; i++) begin
                            digit_q[i] <= 4'h0;
                        end
                        menu_q <= (password_q == 16'h0000) ? PBR_MENU_CT :
                                  PBR_MENU_PASSWORD;
                    end
                end
                PBR_MENU_PASSWORD: begin
                    if (prog_press) begin
                        menu_q <= PBR_MENU_IDLE;
                    end else if (btn2_press) begin
                        digit_q[digit_sel_q] <= (digit_q[digit_sel_q] == 4'd9) ? 4'd0 :
                                                digit_q[digit_sel_q] + 4'd1;
                    end else if (btn1_press && !last_digit) begin
                        digit_sel_q <= digit_sel_q + 2'd1;
                    end else if (btn1_press) begin
                        // Wrong combination restarts entry from 000
                        digit_sel_q <= 2'd0;
                        for (int i = 0; i < 3; i++) begin
                            digit_q[i] <= 4'h0;
                        end
                        menu_q <= pw_match ? PBR_MENU_CT : PBR_MENU_PASSWORD;
                    end
                end
                PBR_MENU_CT: begin
                    if (prog_press) begin
                        menu_q <= PBR_MENU_IDLE;
                    end
                end
                default: menu_q <= PBR_MENU_IDLE;
            endcase
        end
    end

    // Backlight inactivity timer
    logic [15:0] idle_s_q;
    logic standby_q;
    logic [3:0] bl_level_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_s_q <= 16'h0000;
            standby_q <= 1'b0;
            bl_level_q <= PBR_RST_OP_BRIGHT;
        end else begin
            if (any_btn_press) begin
                idle_s_q <= 16'h0000;
                standby_q <= 1'b0;
            end else if (tick && !standby_q) begin
                if (idle_s_q + 16'd1 >= timeout_q) begin
                    standby_q <= 1'b1;
                end
                idle_s_q <= idle_s_q + 16'd1;
            end
            bl_level_q <= standby_q ? stby_bright_q : op_bright_q;
        end
    end

    // Operating hours in tenths of an hour
    logic [8:0] op_sub_q;
    logic [31:0] op_tenths_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_sub_q <= 9'h000;
            op_tenths_q <= 32'h0;
        end else if (tick && measuring) begin
            if (op_sub_q == PBR_TENTH_HOUR_S - 9'd1) begin
                op_sub_q <= 9'h000;
                op_tenths_q <= op_tenths_q + 32'd1;
            end else begin
                op_sub_q <= op_sub_q + 9'd1;
            end
        end
    end

    // Comparator run-time accumulators, seconds and tenths of an hour
    logic [31:0] cmp_sec_q [NUM_CMP];
    logic [31:0] cmp_tenths_q [NUM_CMP];
    logic [8:0] cmp_sub_q [NUM_CMP];
    for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
        always_ff @(posedge clk) begin
            if (!rst_n || remote_cmp_time_clr) begin
                cmp_sec_q[g] <= 32'h0;
                cmp_tenths_q[g] <= 32'h0;
                cmp_sub_q[g] <= 9'h000;
            end else if (tick && cmp_violation[g]) begin
                cmp_sec_q[g] <= (&cmp_sec_q[g]) ? cmp_sec_q[g] : cmp_sec_q[g] + 32'd1;
                if (cmp_sub_q[g] == PBR_TENTH_HOUR_S - 9'd1) begin
                    cmp_sub_q[g] <= 9'h000;
                    cmp_tenths_q[g] <= cmp_tenths_q[g] + 32'd1;
                end else begin
                    cmp_sub_q[g] <= cmp_sub_q[g] + 9'd1;
                end
            end
        end
    end

    // Display selection: 0 operating hours, 1..6 comparators 1A,2A,1B,2B,1C,2C
    wire sel_cmp = (disp_sel >= 3'd1) && (disp_sel <= 3'd6);
    wire [2:0] cmp_idx = sel_cmp ? disp_sel - 3'd1 : 3'd0;
    wire [31:0] sel_sec = cmp_sec_q[cmp_idx];
    wire [31:0] sel_tenths = sel_cmp ? cmp_tenths_q[cmp_idx] : op_tenths_q;
    wire show_hours = ~sel_cmp | (sel_sec > PBR_SEC_DISPLAY_MAX);
    wire [19:0] hours_clamped = (sel_tenths > 32'(PBR_HOURS_DISPLAY_MAX)) ?
                                PBR_HOURS_DISPLAY_MAX : sel_tenths[19:0];
    wire [19:0] disp_d = show_hours ? hours_clamped : sel_sec[19:0];

    logic [19:0] disp_value_q;
    logic [2:0] disp_index_q;
    logic disp_hours_q;
    logic rot_show_q;
    logic rot_cw_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            disp_value_q <= 20'h0;
            disp_index_q <= 3'h0;
            disp_hours_q <= 1'b1;
            rot_show_q <= 1'b0;
            rot_cw_q <= 1'b0;
        end else begin
            disp_value_q <= disp_d;
            disp_index_q <= sel_cmp ? disp_sel : 3'h0;
            disp_hours_q <= show_hours;
            rot_show_q <= (&phase_present) & ~phase_duplicate;
            rot_cw_q <= (&phase_present) & ~phase_duplicate & rotation_cw;
        end
    end

    // Registered panel outputs
    logic [11:0] pw_digits_q;
    logic [1:0] pw_sel_q;
    logic pw_blink_q;
    logic [1:0] menu_out_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pw_digits_q <= 12'h000;
            pw_sel_q <= 2'd0;
            pw_blink_q <= 1'b0;
            menu_out_q <= PBR_MENU_IDLE;
        end else begin
            pw_digits_q <= {digit_q[0], digit_q[1], digit_q[2]};
            pw_sel_q <= digit_sel_q;
            pw_blink_q <= (menu_q == PBR_MENU_PASSWORD) & blink_q;
            menu_out_q <= menu_q;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign reg_err = err_q;
    assign profile_sel = profile_q;
    assign profile_reload = profile_reload_q;
    assign lcd_contrast = contrast_q;
    assign backlight_level = bl_level_q;
    assign standby_active = standby_q;
    assign energy_clear = energy_clear_q;
    assign rotation_show = rot_show_q;
    assign rotation_dir_cw = rot_cw_q;
    assign menu_state = menu_out_q;
    assign pw_digits = pw_digits_q;
    assign pw_digit_sel = pw_sel_q;
    assign pw_blink_on = pw_blink_q;
    assign disp_value = disp_value_q;
    assign disp_index = disp_index_q;
    assign disp_in_hours = disp_hours_q;
endmodule

// [pbr_panel_ctrl_chk.sv]
// Port-level assertions for the panel controller
`timescale 1ns/100ps
module pbr_chk
    import pbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic remote_profile_load,
    input wire logic [2:0] phase_present,
    input wire logic phase_duplicate,
    input wire logic reg_err,
    input wire logic [1:0] profile_sel,
    input wire logic [3:0] lcd_contrast,
    input wire logic [3:0] backlight_level,
    input wire logic energy_clear,
    input wire logic rotation_show
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire wr_prof = reg_wr && reg_addr == PBR_OFS_PROFILE;
    wire wr_tmo = reg_wr && reg_addr == PBR_OFS_STBY_TIMEOUT;
    wire wr_ro = reg_wr && (reg_addr == PBR_OFS_FW_RELEASE || reg_addr == PBR_OFS_SERIAL_LO
        || reg_addr == PBR_OFS_SERIAL_HI);
    sequence clr_req_s;
        reg_wr && reg_addr == PBR_OFS_ENERGY_CLR && reg_wdata == PBR_ENERGY_CLR_CODE;
    endsequence
    sequence clr_pulse_s;
        energy_clear ##1 !energy_clear;
    endsequence
    // Phase fault held long enough to pass the input registers
    sequence bad_phase_s;
        (phase_present != 3'h7 || phase_duplicate) [*4];
    endsequence
    contrast_range_a: assert property (lcd_contrast <= 4'h9)
        else $error("contrast above nine");
    level_range_a: assert property (backlight_level <= 4'h9)
        else $error("brightness above nine");
    contrast_write_a: assert property (reg_wr && reg_addr == PBR_OFS_CONTRAST
        && reg_wdata <= PBR_LEVEL_MAX |=> 16'(lcd_contrast) == $past(reg_wdata))
        else $error("contrast write not applied");
    custom_guard_a: assert property (wr_prof && reg_wdata == 16'h0003
        && !remote_profile_load |=> reg_err && $stable(profile_sel))
        else $error("custom profile set locally");
    profile_range_a: assert property (wr_prof && reg_wdata > PBR_PROFILE_MAX
        |=> reg_err && $stable(profile_sel))
        else $error("profile above three taken");
    energy_pulse_a: assert property (clr_req_s |=> clr_pulse_s)
        else $error("energy clear pulse missing");
    energy_cause_a: assert property ($rose(energy_clear) |-> $past(reg_wr)
        && $past(reg_addr) == PBR_OFS_ENERGY_CLR)
        else $error("energy clear without write");
    rotation_hide_a: assert property (bad_phase_s |-> !rotation_show)
        else $error("rotation shown with phase fault");
    ro_write_a: assert property (wr_ro |=> reg_err)
        else $error("read-only write not refused");
    timeout_range_a: assert property (wr_tmo && (reg_wdata < PBR_TIMEOUT_MIN
        || reg_wdata > PBR_TIMEOUT_MAX) |=> reg_err)
        else $error("timeout out of range taken");
endmodule

bind pbr_panel_ctrl pbr_chk u_pbr_chk (.*);

// [pbr_operator.sv]
// Behavioural operator pressing the front-panel buttons
`timescale 1ns/100ps
module pbr_operator (
    input wire logic clk,
    output logic btn1_pin,
    output logic btn2_pin,
    output logic btn3_pin,
    output logic prog_pin
);
    logic [3:0] held;
    assign {prog_pin, btn3_pin, btn2_pin, btn1_pin} = held;
    initial held = 4'h0;
    // Holds one button past the pin synchroniser, then lets the result settle
    task automatic press(input int which);
        @(posedge clk);
        #1;
        held = 4'h1 << which;
        repeat (6) @(posedge clk);
        #1;
        held = 4'h0;
        repeat (8) @(posedge clk);
        #1;
    endtask
endmodule

// [test_panel_backlight_runtime_ctrl.sv]
// Self-checking bench for the panel controller
`timescale 1ns/100ps
module test_panel_backlight_runtime_ctrl
    import pbr_pkg::*;
;
    localparam int TK = 20;
    // Arbitrary identity values
    localparam logic [19:0] SN = 20'h3C2B1;
    localparam logic [9:0] FW = 10'h1C8;
    logic clk, rst_n, reg_wr, reg_rd, remote_profile_load, remote_cmp_time_clr;
    logic phase_duplicate, rotation_cw, measuring, reg_rvalid, reg_err, profile_reload;
    logic standby_active, energy_clear, rotation_show, rotation_dir_cw, pw_blink_on;
    logic disp_in_hours, err_v, ec_v, b;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_v, rv;
    logic [2:0] phase_present, disp_sel, disp_index;
    logic [5:0] cmp_violation;
    logic [1:0] profile_sel, menu_state, pw_digit_sel;
    logic [3:0] lcd_contrast, backlight_level;
    logic [11:0] pw_digits;
    logic [19:0] disp_value;
    wire btn1_pin, btn2_pin, btn3_pin, prog_pin;
    int n_errors, total_checks, cyc, seed, k;

    pbr_operator u_pbr_operator (.clk(clk), .btn1_pin(btn1_pin), .btn2_pin(btn2_pin),
        .btn3_pin(btn3_pin), .prog_pin(prog_pin));
    pbr_panel_ctrl #(.TICK_CYCLES(TK), .SERIAL_NUMBER(SN), .FW_RELEASE(FW))
        u_pbr_panel_ctrl (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One register access; answer sampled after the take edge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        idle(1);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        idle(1);
        {reg_wr, reg_rd} = 2'h0;
        {err_v, ec_v} = {reg_err, energy_clear};
        rd_v = reg_rvalid === 1'b1 ? reg_rdata : 16'hBAD0;
    endtask
    task automatic wr_e(input logic [15:0] a, input logic [15:0] d, input logic e);
        acc(1'b1, a, d);
        chk(20'(err_v), 20'(e));
    endtask
    task automatic rd_e(input logic [15:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(20'(rd_v), 20'(e));
    endtask
    task automatic enter(input logic [11:0] code);
        for (int i = 0; i < 3; i++) begin
            repeat (code[11 - 4 * i -: 4]) u_pbr_operator.press(1);
            chk(20'(pw_digit_sel), 20'(i));
            chk(20'(pw_digits[11 - 4 * i -: 4]), 20'(code[11 - 4 * i -: 4]));
            u_pbr_operator.press(0);
        end
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, remote_profile_load, remote_cmp_time_clr} = 5'h00;
        {reg_addr, reg_wdata, cmp_violation, disp_sel} = 41'h0;
        {phase_present, phase_duplicate, rotation_cw, measuring} = 6'h3B;
        {n_errors, total_checks, cyc, k} = 128'h0;
        seed = 32'h7FAD;
        idle(4);
        rst_n = 1'b1;
        chk(20'(lcd_contrast), 20'h5);
        chk(20'(backlight_level), 20'h6);
        rd_e(PBR_OFS_STBY_TIMEOUT, 16'h0384);
        rd_e(PBR_OFS_STBY_BRIGHT, 16'h0000);
        rd_e(PBR_OFS_FW_RELEASE, 16'(FW));
        wr_e(PBR_OFS_FW_RELEASE, 16'h0001, 1'b1);
        wr_e(PBR_OFS_SERIAL_LO, 16'h0001, 1'b1);
        rd_e(PBR_OFS_SERIAL_LO, SN[15:0]);
        rd_e(PBR_OFS_SERIAL_HI, 16'(SN[19:16]));
        rd_e(16'h0777, 16'h0000);
        chk(20'(err_v), 20'h1);
        wr_e(PBR_OFS_CONTRAST, 16'h000A, 1'b1);
        wr_e(PBR_OFS_OP_BRIGHT, 16'h000A, 1'b1);
        for (k = 0; k < 7; k++) begin
            rv = k == 6 ? 16'h0009 : 16'({$random(seed)} % 10);
            wr_e(PBR_OFS_CONTRAST, rv, 1'b0);
            chk(20'(lcd_contrast), 20'(rv));
        end
        for (k = 0; k < 4; k++) begin
            remote_profile_load = k == 3 || $random(seed) % 2 != 0;
            wr_e(PBR_OFS_PROFILE, 16'(k), 1'b0);
            chk(20'(profile_sel), 20'(k));
        end
        remote_profile_load = 1'b0;
        wr_e(PBR_OFS_PROFILE, 16'h0001, 1'b0);
        wr_e(PBR_OFS_PROFILE, 16'h0003, 1'b1);
        wr_e(PBR_OFS_PROFILE, 16'h0004, 1'b1);
        chk(20'(profile_sel), 20'h1);
        wr_e(PBR_OFS_ENERGY_CLR, 16'h0001, 1'b0);
        chk(20'(ec_v), 20'h1);
        wr_e(PBR_OFS_ENERGY_CLR, 16'h0002, 1'b0);
        chk(20'(ec_v), 20'h0);
        wr_e(PBR_OFS_STBY_TIMEOUT, 16'h003B, 1'b1);
        wr_e(PBR_OFS_STBY_TIMEOUT, 16'h2710, 1'b1);
        wr_e(PBR_OFS_STBY_TIMEOUT, 16'h270F, 1'b0);
        wr_e(PBR_OFS_STBY_TIMEOUT, 16'h003C, 1'b0);
        rd_e(PBR_OFS_STBY_TIMEOUT, 16'h003C);
        for (k = 0; k < 3; k++) begin
            {phase_present, phase_duplicate} = k == 0 ? 4'hE : (k == 1 ? 4'h6 : 4'hF);
            rotation_cw = k == 1 ? 1'b0 : $random(seed) % 2 != 0;
            idle(8);
            chk(20'(rotation_show), 20'(k == 0));
            chk(20'(rotation_dir_cw), 20'(k == 0 && rotation_cw));
        end
        {phase_present, phase_duplicate} = 4'hE;
        wr_e(PBR_OFS_OP_BRIGHT, 16'h0007, 1'b0);
        wr_e(PBR_OFS_STBY_BRIGHT, 16'h0002, 1'b0);
        u_pbr_operator.press(2);
        idle(55 * TK);
        chk(20'(standby_active), 20'h0);
        idle(10 * TK);
        chk(20'(standby_active), 20'h1);
        chk(20'(backlight_level), 20'h2);
        u_pbr_operator.press(2);
        chk(20'(backlight_level), 20'h7);
        u_pbr_operator.press(3);
        chk(20'(menu_state), 20'(PBR_MENU_CT));
        u_pbr_operator.press(3);
        wr_e(PBR_OFS_PASSWORD, 16'h007B, 1'b0);
        u_pbr_operator.press(3);
        chk(20'(menu_state), 20'(PBR_MENU_PASSWORD));
        chk(20'(pw_digits), 20'h0);
        b = pw_blink_on;
        idle(TK);
        chk(20'(pw_blink_on), 20'(!b));
        for (k = 0; k < 2; k++) begin
            enter(k == 1 ? 12'h123 : 12'h124);
            chk(20'(menu_state), 20'(k == 1 ? PBR_MENU_CT : PBR_MENU_PASSWORD));
            chk(20'(pw_digits), 20'h0);
        end
        u_pbr_operator.press(3);
        {cmp_violation, measuring} = 7'h08;
        idle(30 * TK);
        {cmp_violation, disp_sel} = 9'h3;
        idle(4);
        chk(20'(disp_value >= 29 && disp_value <= 31), 20'h1);
        chk(20'({disp_index, disp_in_hours}), 20'h6);
        {disp_sel, measuring} = 4'h3;
        idle(4);
        chk(disp_value, 20'h0);
        idle(11000 - cyc);
        disp_sel = 3'h0;
        idle(4);
        chk(20'({disp_index, disp_in_hours}), 20'h1);
        chk(disp_value, 20'h1);
        {remote_cmp_time_clr, disp_sel} = 4'hB;
        idle(2);
        remote_cmp_time_clr = 1'b0;
        idle(4);
        chk(disp_value, 20'h0);
        conclude();
    end
endmodule
